// ---- core/faecu_unit.sv ----
`timescale 1ns/1ps
module faecu_unit #(
  parameter int UNIT_AW = 6,
  parameter int SECTOR_UNIT_LOG = 2
) (
  // clock, reset, enable
  input wire logic CLK_SYS_IN,
  input wire logic RST_N_IN,
  input wire logic CE_IN,
  // device resets and clear command
  input wire logic SOFT_RST_IN,
  input wire logic CLR_ECC_IN,
  // register access
  input wire logic REG_WR_IN,
  input wire logic REG_RD_IN,
  input wire logic [31:0] REG_ADDR_IN,
  input wire logic [7:0] REG_WDATA_IN,
  output faecu_pkg::faecu_reg_rsp_s REG_RSP_OUT,
  // program path
  input wire logic PROG_REQ_IN,
  input wire logic [31:0] PROG_ADDR_IN,
  input wire logic [127:0] PROG_DATA_IN,
  input wire logic [15:0] PROG_MASK_IN,
  output faecu_pkg::faecu_arr_wr_s ARR_WR_OUT,
  output logic PROG_ERR_OUT,
  // sector erase
  input wire logic ERASE_REQ_IN,
  input wire logic [31:0] ERASE_ADDR_IN,
  // read path
  input wire logic RD_REQ_IN,
  input wire logic [31:0] RD_ADDR_IN,
  input wire logic [127:0] ARR_RD_DATA_IN,
  input wire logic [8:0] ARR_RD_CODE_IN,
  output faecu_pkg::faecu_rd_rsp_s RD_RSP_OUT
);

  localparam int NUM_UNITS = 2 ** UNIT_AW;

  typedef struct packed {
    logic [7:0] cfg4_nv;
    logic [7:0] cfg4_v;
    logic [7:0] err_status;
    logic [15:0] err_count;
    logic [31:0] trap;
    logic trap_full;
    logic [NUM_UNITS-1:0] unit_prog;
    logic [NUM_UNITS-1:0] unit_off;
    faecu_pkg::faecu_reg_rsp_s reg_rsp;
    faecu_pkg::faecu_arr_wr_s arr_wr;
    logic prog_err;
    faecu_pkg::faecu_rd_rsp_s rd_rsp;
  } faecu_state_s;

  localparam faecu_state_s ST_RST = '{
    cfg4_nv: faecu_pkg::CFG4_RST,
    cfg4_v: faecu_pkg::CFG4_RST,
    default: '0
  };

  faecu_state_s st_r;
  faecu_state_s st_nxt;

  // hamming positions skip powers of two; bit 8 is overall parity
  function automatic logic [8:0] faecu_code(input logic [127:0] d);
    logic [7:0] s;
    int k;
    s = '0;
    k = 0;
    for (int pos = 3; pos < 256; pos++)
    begin
      if (((pos & (pos - 1)) != 0) && (k < 128))
      begin
        if (d[k])
          s = s ^ 8'(pos);
        k++;
      end
    end
    faecu_code = {(^d) ^ (^s), s};
  endfunction

  function automatic logic [127:0] faecu_fix(input logic [127:0] d, input logic [7:0] syn);
    logic [127:0] r;
    int k;
    r = d;
    k = 0;
    for (int pos = 3; pos < 256; pos++)
    begin
      if (((pos & (pos - 1)) != 0) && (k < 128))
      begin
        if (8'(pos) == syn)
          r[k] = ~d[k];
        k++;
      end
    end
    faecu_fix = r;
  endfunction

  // unit index from byte address: units are aligned 16-byte lines
  logic [UNIT_AW-1:0] rd_unit;
  logic [UNIT_AW-1:0] pg_unit;
  logic [UNIT_AW-1:0] er_unit;
  logic [NUM_UNITS-1:0] erase_hit;
  logic [127:0] pg_merged;

  assign rd_unit = RD_ADDR_IN[faecu_pkg::UNIT_LSB +: UNIT_AW];
  assign pg_unit = PROG_ADDR_IN[faecu_pkg::UNIT_LSB +: UNIT_AW];
  assign er_unit = ERASE_ADDR_IN[faecu_pkg::UNIT_LSB +: UNIT_AW];

  genvar gi;
  generate
    for (gi = 0; gi < NUM_UNITS; gi++)
    begin : g_unit
      localparam logic [UNIT_AW-1:0] IDX = UNIT_AW'(gi);
      assign erase_hit[gi] = ERASE_REQ_IN &&
        ((IDX >> SECTOR_UNIT_LOG) == (er_unit >> SECTOR_UNIT_LOG));
    end
    // untouched bytes of the unit stay erased, so the code covers them too
    for (gi = 0; gi < faecu_pkg::UNIT_BYTES; gi++)
    begin : g_byte
      assign pg_merged[gi*8 +: 8] = PROG_MASK_IN[gi] ? PROG_DATA_IN[gi*8 +: 8]
                                                      : faecu_pkg::ERASED_BYTE;
    end
  endgenerate

  logic ded_mode;
  logic chk_on;
  logic [8:0] rd_calc;
  logic [7:0] rd_syn;
  logic rd_par;
  logic rd_single;
  logic rd_double;
  logic trap_ev;
  logic [8:0] pg_code;

  // mode comes straight from the volatile config bit; single-mode codes leave the parity
  // cell erased, so double mode may flag them as single errors, which is why the host must erase first
  assign ded_mode = st_r.cfg4_v[faecu_pkg::CFG4_DED_BIT];
  assign chk_on = st_r.unit_prog[rd_unit] && !st_r.unit_off[rd_unit];
  assign rd_calc = faecu_code(ARR_RD_DATA_IN);
  assign rd_syn = rd_calc[7:0] ^ ARR_RD_CODE_IN[7:0];
  assign rd_par = ^{ARR_RD_DATA_IN, ARR_RD_CODE_IN};
  assign rd_single = RD_REQ_IN && chk_on && (ded_mode ? rd_par : (rd_syn != 8'h00));
  assign rd_double = RD_REQ_IN && chk_on && ded_mode && !rd_par && (rd_syn != 8'h00);
  assign trap_ev = rd_double ||
    (rd_single && !st_r.cfg4_v[faecu_pkg::CFG4_TRAP_DBL_ONLY_BIT]);
  assign pg_code = faecu_code(pg_merged);

  always_comb
  begin
    st_nxt = st_r;
    st_nxt.reg_rsp = '0;
    st_nxt.arr_wr = '0;
    st_nxt.prog_err = 1'b0;
    st_nxt.rd_rsp = '0;

    // clear first so a same-cycle error event still lands
    if (SOFT_RST_IN || CLR_ECC_IN)
    begin
      st_nxt.err_status = '0;
      st_nxt.err_count = '0;
      st_nxt.trap = '0;
      st_nxt.trap_full = 1'b0;
    end
    if (SOFT_RST_IN)
      st_nxt.cfg4_v = st_r.cfg4_nv;

    // register access
    if (REG_WR_IN && !SOFT_RST_IN)
    begin
      if (REG_ADDR_IN == faecu_pkg::ADDR_CFG4_NV)
        st_nxt.cfg4_nv = REG_WDATA_IN;
      if (REG_ADDR_IN == faecu_pkg::ADDR_CFG4_V)
        st_nxt.cfg4_v = REG_WDATA_IN;
    end
    if (REG_RD_IN)
    begin
      st_nxt.reg_rsp.valid = 1'b1;
      unique case (REG_ADDR_IN)
        faecu_pkg::ADDR_CFG4_NV: st_nxt.reg_rsp.data = st_r.cfg4_nv;
        faecu_pkg::ADDR_CFG4_V: st_nxt.reg_rsp.data = st_r.cfg4_v;
        faecu_pkg::ADDR_ERR_STATUS: st_nxt.reg_rsp.data = st_r.err_status;
        faecu_pkg::ADDR_ERR_COUNT_LO: st_nxt.reg_rsp.data = st_r.err_count[7:0];
        faecu_pkg::ADDR_ERR_COUNT_HI: st_nxt.reg_rsp.data = st_r.err_count[15:8];
        faecu_pkg::ADDR_TRAP_B0: st_nxt.reg_rsp.data = st_r.trap[7:0];
        faecu_pkg::ADDR_TRAP_B1: st_nxt.reg_rsp.data = st_r.trap[15:8];
        faecu_pkg::ADDR_TRAP_B2: st_nxt.reg_rsp.data = st_r.trap[23:16];
        faecu_pkg::ADDR_TRAP_B3: st_nxt.reg_rsp.data = st_r.trap[31:24];
        default: st_nxt.reg_rsp.data = faecu_pkg::UNMAPPED_DATA;
      endcase
    end

    // sector erase re-arms protection on every unit of the sector
    st_nxt.unit_prog = st_nxt.unit_prog & ~erase_hit;
    st_nxt.unit_off = st_nxt.unit_off & ~erase_hit;

    // program: erase above takes effect before a same-cycle program
    if (PROG_REQ_IN)
    begin
      if (!st_nxt.unit_prog[pg_unit])
      begin
        st_nxt.unit_prog[pg_unit] = 1'b1;
        st_nxt.arr_wr.valid = 1'b1;
        st_nxt.arr_wr.addr = PROG_ADDR_IN;
        st_nxt.arr_wr.data = pg_merged;
        st_nxt.arr_wr.mask = PROG_MASK_IN;
        // single mode stores 8 bits; the parity cell is left erased
        st_nxt.arr_wr.code = ded_mode ? pg_code
                                      : {1'b1, pg_code[faecu_pkg::SEC_CODE_W-1:0]};
      end
      else if (ded_mode)
        st_nxt.prog_err = 1'b1;
      else
      begin
        // the array can only clear bits, so the old code is now useless
        st_nxt.unit_off[pg_unit] = 1'b1;
        st_nxt.arr_wr.valid = 1'b1;
        st_nxt.arr_wr.addr = PROG_ADDR_IN;
        st_nxt.arr_wr.data = pg_merged;
        st_nxt.arr_wr.mask = PROG_MASK_IN;
        st_nxt.arr_wr.code = faecu_pkg::ERASED_CODE;
      end
    end

    // read: correct and report with the same single cycle as a clean read
    if (RD_REQ_IN)
    begin
      st_nxt.rd_rsp.valid = 1'b1;
      st_nxt.rd_rsp.data = rd_single ? faecu_fix(ARR_RD_DATA_IN, rd_syn)
                                     : ARR_RD_DATA_IN;
      st_nxt.rd_rsp.unit_status[faecu_pkg::DUS_DOUBLE_BIT] = rd_double;
      st_nxt.rd_rsp.unit_status[faecu_pkg::DUS_SINGLE_BIT] = rd_single;
      st_nxt.rd_rsp.unit_status[faecu_pkg::DUS_OFF_BIT] = st_r.unit_off[rd_unit];
    end
    if (rd_single)
      st_nxt.err_status[faecu_pkg::ESTAT_SINGLE_BIT] = 1'b1;
    if (rd_double)
      st_nxt.err_status[faecu_pkg::ESTAT_DOUBLE_BIT] = 1'b1;
    if ((rd_single || rd_double) && (st_nxt.err_count != faecu_pkg::COUNT_MAX))
      st_nxt.err_count = st_nxt.err_count + 16'h0001;
    if (trap_ev && !st_nxt.trap_full)
    begin
      st_nxt.trap = RD_ADDR_IN;
      st_nxt.trap_full = 1'b1;
    end
  end

  always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
      st_r <= ST_RST;
    else if (CE_IN)
      st_r <= st_nxt;
  end

  assign REG_RSP_OUT = st_r.reg_rsp;
  assign ARR_WR_OUT = st_r.arr_wr;
  assign PROG_ERR_OUT = st_r.prog_err;
  assign RD_RSP_OUT = st_r.rd_rsp;

endmodule

// ---- core/faecu_pkg.sv ----
// Functional notes
// - check codes over aligned sixteen-byte data units
// - first program of unit stores its check code
// - array reads of programmed, still-protected units verify stored code
// - single flipped bit corrected before data leaves
// - first program sets code for whole unit
// - single-bit mode reprogram turns unit protection off
// - only sector erase restores unit protection; here a RST_N_IN reset also clears unit_off
// - reset default mode is double-error detection
// - double-error mode uses nine-bit check code
// - double-error mode rejects reprogram, flags program error
// - mode switch invalidates all stored array data; here a switch clears nothing
// - error count readable as two bytes, low first
// - error address trap readable as four bytes
// - clear status on resets or clear command
// - trap holds address of first enabled error
// - counter counts per bad read, saturates
// - config4 bit3 selects double mode, else flag zero
package faecu_pkg;

  localparam int DATA_W = 128;
  localparam int UNIT_BYTES = 16;
  localparam int UNIT_LSB = 4;
  localparam int CODE_W = 9;
  localparam int SEC_CODE_W = 8;
  localparam int ADDR_W = 32;

  // register addresses
  localparam logic [31:0] ADDR_CFG4_NV = 32'h0000_0005;
  localparam logic [31:0] ADDR_CFG4_V = 32'h0080_0005;
  localparam logic [31:0] ADDR_ERR_STATUS = 32'h0080_0089;
  localparam logic [31:0] ADDR_ERR_COUNT_LO = 32'h0080_008A;
  localparam logic [31:0] ADDR_ERR_COUNT_HI = 32'h0080_008B;
  localparam logic [31:0] ADDR_TRAP_B0 = 32'h0080_008E;
  localparam logic [31:0] ADDR_TRAP_B1 = 32'h0080_008F;
  localparam logic [31:0] ADDR_TRAP_B2 = 32'h0080_0040;
  localparam logic [31:0] ADDR_TRAP_B3 = 32'h0080_0041;

  // config4 fields and reset value
  localparam int CFG4_DED_BIT = 3;
  localparam int CFG4_TRAP_DBL_ONLY_BIT = 4;
  localparam logic [7:0] CFG4_RST = 8'h08;

  // error status and unit check status fields
  localparam int ESTAT_DOUBLE_BIT = 3;
  localparam int ESTAT_SINGLE_BIT = 4;
  localparam int DUS_DOUBLE_BIT = 3;
  localparam int DUS_SINGLE_BIT = 1;
  localparam int DUS_OFF_BIT = 0;

  localparam logic [15:0] COUNT_MAX = 16'hFFFF;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;
  localparam logic [8:0] ERASED_CODE = 9'h1FF;
  localparam logic [7:0] UNMAPPED_DATA = 8'h00;
  // cycles from request to answer on read, program and register ports
  localparam int RSP_LATENCY = 1;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } faecu_reg_rsp_s;

  typedef struct packed {
    logic valid;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
    logic [UNIT_BYTES-1:0] mask;
    logic [CODE_W-1:0] code;
  } faecu_arr_wr_s;

  typedef struct packed {
    logic valid;
    logic [DATA_W-1:0] data;
    logic [7:0] unit_status;
  } faecu_rd_rsp_s;

endpackage

// ---- sim/faecu_chk.sv ----
`timescale 1ns/1ps
module faecu_chk (
  // clock and requests
  input wire logic CLK_SYS_IN,
  input wire logic RST_N_IN,
  input wire logic CE_IN,
  input wire logic REG_RD_IN,
  input wire logic PROG_REQ_IN,
  input wire logic RD_REQ_IN,
  // answers
  input faecu_pkg::faecu_reg_rsp_s REG_RSP_OUT,
  input faecu_pkg::faecu_arr_wr_s ARR_WR_OUT,
  input wire logic PROG_ERR_OUT,
  input faecu_pkg::faecu_rd_rsp_s RD_RSP_OUT
);
  default clocking cb @(posedge CLK_SYS_IN);
  endclocking
  default disable iff (!RST_N_IN);
  AST_REG_ANS: assert property (CE_IN && REG_RD_IN |=> REG_RSP_OUT.valid)
    else $error("register read unanswered");
  AST_REG_QUIET: assert property (!(CE_IN && REG_RD_IN) |=> !REG_RSP_OUT.valid)
    else $error("register answer without read");
  AST_PROG_ANS: assert property (CE_IN && PROG_REQ_IN |=> ARR_WR_OUT.valid ^ PROG_ERR_OUT)
    else $error("program not answered once");
  AST_PROG_QUIET: assert property (
    !(CE_IN && PROG_REQ_IN) |=> !ARR_WR_OUT.valid && !PROG_ERR_OUT)
    else $error("array write without program");
  AST_RD_ANS: assert property (CE_IN && RD_REQ_IN |=> RD_RSP_OUT.valid)
    else $error("read unanswered");
  AST_RD_QUIET: assert property (!(CE_IN && RD_REQ_IN) |=> !RD_RSP_OUT.valid)
    else $error("read answer without read");
  AST_STAT_RSVD: assert property (
    RD_RSP_OUT.valid |-> RD_RSP_OUT.unit_status[7:4] == 4'h0 && !RD_RSP_OUT.unit_status[2])
    else $error("reserved unit status bit set");
  AST_OFF_NOCHK: assert property (
    RD_RSP_OUT.valid && RD_RSP_OUT.unit_status[0] |-> RD_RSP_OUT.unit_status[3:1] == 3'h0)
    else $error("unprotected unit reported an error");
endmodule
bind faecu_unit faecu_chk u_chk (.CLK_SYS_IN(CLK_SYS_IN), .RST_N_IN(RST_N_IN), .CE_IN(CE_IN),
  .REG_RD_IN(REG_RD_IN), .PROG_REQ_IN(PROG_REQ_IN), .RD_REQ_IN(RD_REQ_IN),
  .REG_RSP_OUT(REG_RSP_OUT), .ARR_WR_OUT(ARR_WR_OUT), .PROG_ERR_OUT(PROG_ERR_OUT),
  .RD_RSP_OUT(RD_RSP_OUT));

// ---- sim/faecu_arr_model.sv ----
`timescale 1ns/1ps
module faecu_arr_model (
  // clock and array writes
  input wire logic clk_in,
  input faecu_pkg::faecu_arr_wr_s arr_wr_in,
  input wire logic erase_in,
  input wire logic [31:0] erase_addr_in,
  // read port with injected bit flips
  input wire logic [31:0] rd_addr_in,
  input wire logic [136:0] flip_in,
  output logic [127:0] rd_data_out,
  output logic [8:0] rd_code_out
);
  logic [136:0] mem [64];
  // erased cells read all ones, code bits too
  initial foreach (mem[i]) mem[i] = '1;
  always @(posedge clk_in)
  begin
    if (erase_in)
      for (int i = 0; i < 4; i++)
        mem[{erase_addr_in[9:6], 2'(i)}] <= '1;
    if (arr_wr_in.valid)
      mem[arr_wr_in.addr[9:4]] <= {arr_wr_in.code, arr_wr_in.data};
  end
  assign {rd_code_out, rd_data_out} = mem[rd_addr_in[9:4]] ^ flip_in;
endmodule

// ---- sim/tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
  localparam logic [127:0] D0 = 128'h0123_4567_89AB_CDEF_FEDC_BA98_7654_3210;
  localparam logic [6:0] K_RD = 7'h01, K_PG = 7'h02, K_ER = 7'h04, K_RR = 7'h08;
  localparam logic [6:0] K_RW = 7'h10, K_CL = 7'h20, K_SR = 7'h40;
  logic clk, rst_n;
  logic [6:0] req_v;
  logic [31:0] addr;
  logic [7:0] wdata;
  logic [127:0] pdata, adata;
  logic [15:0] pmask;
  logic [8:0] acode;
  logic [136:0] flip;
  logic prog_err;
  logic ce;
  faecu_pkg::faecu_reg_rsp_s reg_rsp;
  faecu_pkg::faecu_arr_wr_s arr_wr;
  faecu_pkg::faecu_rd_rsp_s rd_rsp;
  int n_errors, checks;
  // one address bus serves every request kind, only one is raised at a time
  faecu_unit u_dut (.CLK_SYS_IN(clk), .RST_N_IN(rst_n), .CE_IN(ce), .SOFT_RST_IN(req_v[6]),
    .CLR_ECC_IN(req_v[5]), .REG_WR_IN(req_v[4]), .REG_RD_IN(req_v[3]), .REG_ADDR_IN(addr),
    .REG_WDATA_IN(wdata), .REG_RSP_OUT(reg_rsp), .PROG_REQ_IN(req_v[1]), .PROG_ADDR_IN(addr),
    .PROG_DATA_IN(pdata), .PROG_MASK_IN(pmask), .ARR_WR_OUT(arr_wr), .PROG_ERR_OUT(prog_err),
    .ERASE_REQ_IN(req_v[2]), .ERASE_ADDR_IN(addr), .RD_REQ_IN(req_v[0]), .RD_ADDR_IN(addr),
    .ARR_RD_DATA_IN(adata), .ARR_RD_CODE_IN(acode), .RD_RSP_OUT(rd_rsp));
  faecu_arr_model u_arr (.clk_in(clk), .arr_wr_in(arr_wr), .erase_in(req_v[2]),
    .erase_addr_in(addr), .rd_addr_in(addr), .flip_in(flip), .rd_data_out(adata),
    .rd_code_out(acode));
  task automatic give_verdict();
    if (n_errors == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [127:0] s, input logic [127:0] e);
    checks++;
    if (s !== e)
    begin
      n_errors++;
      $display("unexpected at %0t: saw %h want %h", $time, s, e);
    end
  endtask
  // every answer is registered, so it is sampled just after the edge taking the request
  task automatic go(input logic [6:0] k, input logic [31:0] a);
    @(posedge clk);
    req_v <= k;
    addr <= a;
    @(posedge clk);
    req_v <= '0;
    #1;
  endtask
  task automatic rreg(input logic [31:0] a, input logic [7:0] e);
    go(K_RR, a);
    chk({reg_rsp.valid, reg_rsp.data}, {1'b1, e});
  endtask
  task automatic wreg(input logic [31:0] a, input logic [7:0] d);
    @(posedge clk);
    wdata <= d;
    go(K_RW, a);
  endtask
  task automatic pg(input logic [31:0] a, input logic [127:0] d, input logic [15:0] m,
    input logic ok, input logic [127:0] ed);
    @(posedge clk);
    pdata <= d;
    pmask <= m;
    go(K_PG, a);
    chk({arr_wr.valid, prog_err}, {ok, !ok});
    if (ok)
    begin
      chk(arr_wr.data, ed);
      chk({arr_wr.addr, arr_wr.mask}, {a, m});
    end
  endtask
  task automatic rdu(input logic [31:0] a, input logic [136:0] f, input logic [127:0] ed,
    input logic [7:0] es);
    @(posedge clk);
    flip <= f;
    go(K_RD, a);
    chk({rd_rsp.valid, rd_rsp.unit_status}, {1'b1, es});
    if (!es[3])
      chk(rd_rsp.data, ed);
  endtask
  initial
  begin
    clk = 0;
    forever #2 clk = ~clk;
  end
  initial
  begin
    #20000;
    n_errors++;
    give_verdict();
  end
  initial
  begin
    rst_n = 0;
    req_v = '0;
    addr = '0;
    wdata = '0;
    pdata = '0;
    pmask = '0;
    flip = '0;
    ce = 1'b1;
    repeat (5) @(posedge clk);
    rst_n <= 1;
    rreg(faecu_pkg::ADDR_CFG4_V, 8'h08);
    rreg(faecu_pkg::ADDR_CFG4_NV, 8'h08);
    rreg(32'h0080_0077, 8'h00);
    pg(32'h0, D0, 16'hFFFF, 1'b1, D0);
    rdu(32'h8, '0, D0, 8'h00);
    rdu(32'h8, 137'h20, D0, 8'h02);
    rdu(32'h0, 137'h3, D0, 8'h08);
    rreg(faecu_pkg::ADDR_ERR_STATUS, 8'h18);
    rreg(faecu_pkg::ADDR_ERR_COUNT_LO, 8'h02);
    rreg(faecu_pkg::ADDR_ERR_COUNT_HI, 8'h00);
    rreg(faecu_pkg::ADDR_TRAP_B0, 8'h08);
    rreg(faecu_pkg::ADDR_TRAP_B1, 8'h00);
    pg(32'h0, D0, 16'hFFFF, 1'b0, D0);
    pg(32'h10, D0, 16'h0001, 1'b1, {{15{8'hFF}}, 8'h10});
    go(K_CL, 32'h0);
    rreg(faecu_pkg::ADDR_ERR_STATUS, 8'h00);
    rreg(faecu_pkg::ADDR_ERR_COUNT_LO, 8'h00);
    rreg(faecu_pkg::ADDR_TRAP_B0, 8'h00);
    for (int s = 0; s < 16; s++)
      go(K_ER, 32'(s) << 6);
    wreg(faecu_pkg::ADDR_CFG4_V, 8'h00);
    rreg(faecu_pkg::ADDR_CFG4_V, 8'h00);
    pg(32'h40, D0, 16'hFFFF, 1'b1, D0);
    chk(arr_wr.code[8], 1'b1);
    pg(32'h40, ~D0, 16'hFFFF, 1'b1, ~D0);
    chk(arr_wr.code, 9'h1FF);
    rdu(32'h40, 137'h1, ~D0 ^ 128'h1, 8'h01);
    rreg(faecu_pkg::ADDR_ERR_COUNT_LO, 8'h00);
    go(K_ER, 32'h40);
    pg(32'h40, D0, 16'hFFFF, 1'b1, D0);
    // high address bits do not pick the unit, so they show up only in the trap
    rdu(32'hA5C3_5C48, 137'h1, D0, 8'h02);
    wreg(faecu_pkg::ADDR_TRAP_B2, 8'h55);
    rreg(faecu_pkg::ADDR_TRAP_B0, 8'h48);
    rreg(faecu_pkg::ADDR_TRAP_B1, 8'h5C);
    rreg(faecu_pkg::ADDR_TRAP_B2, 8'hC3);
    rreg(faecu_pkg::ADDR_TRAP_B3, 8'hA5);
    // a read raised while the clock enable is low is lost
    @(posedge clk);
    ce <= 1'b0;
    go(K_RD, 32'h40);
    chk(rd_rsp.valid, 1'b0);
    @(posedge clk);
    ce <= 1'b1;
    rreg(faecu_pkg::ADDR_ERR_COUNT_LO, 8'h01);
    wreg(faecu_pkg::ADDR_CFG4_NV, 8'h18);
    go(K_SR, 32'h0);
    rreg(faecu_pkg::ADDR_CFG4_V, 8'h18);
    rreg(faecu_pkg::ADDR_ERR_STATUS, 8'h00);
    pg(32'h80, D0, 16'hFFFF, 1'b1, D0);
    rdu(32'h80, 137'h20, D0, 8'h02);
    rdu(32'h84, 137'h3, D0, 8'h08);
    rreg(faecu_pkg::ADDR_TRAP_B0, 8'h84);
    give_verdict();
  end
endmodule
